// ==== core/idf_pkg.sv ====
// Constants and types shared by the interpolating datapath files.
// Assumes one reference clock that runs at the converter update rate.
package idf_pkg;

  // ----------------------------------------------------------------
  // Widths and rates
  // ----------------------------------------------------------------
  localparam int DATA_W           = 14;
  localparam int COEF_W           = 16;
  localparam int COEF_FRAC        = 14;
  localparam int PROD_W           = 31;
  localparam int ACC_W            = 36;
  localparam int NUM_TAPS         = 43;
  localparam int LINE_LEN         = 22;
  localparam int NUM_PAIRS        = 11;
  localparam int CENTER_IDX       = 10;
  localparam int FIFO_DEPTH       = 8;
  localparam int INTERP_FACTOR    = 2;
  localparam int STUFF_FACTOR     = 2;
  localparam int UPDATES_PER_WORD = INTERP_FACTOR * STUFF_FACTOR;
  localparam int MAX_IN_MSPS      = 160;
  localparam int MAX_UPDATE_MSPS  = 400;
  localparam int REF_CLK_MHZ      = 40;

  // ----------------------------------------------------------------
  // Codes and coefficients
  // ----------------------------------------------------------------
  localparam logic [DATA_W-1:0] MIDSCALE_CODE = 14'h2000;
  localparam logic [DATA_W-1:0] ZERO_CODE     = 14'h0000;
  localparam logic signed [ACC_W-1:0] SAT_HI  = 36'sh000001fff;
  localparam logic signed [ACC_W-1:0] SAT_LO  = 36'shfffffe000;
  localparam logic signed [COEF_W-1:0] CENTER_COEF = 16'sh2000;
  // Outermost pair first; plain unwindowed half-band values
  localparam logic signed [COEF_W-1:0] PAIR_COEF [NUM_PAIRS] = '{
    16'sh00f8, 16'shfeee, 16'sh0133, 16'shfea4, 16'sh0191, 16'shfe26,
    16'sh0243, 16'shfd17, 16'sh0413, 16'shf936, 16'sh145f};

  // ----------------------------------------------------------------
  // Frame phases and modes
  // ----------------------------------------------------------------
  localparam logic [1:0] PHASE_LOAD  = 2'h0;
  localparam logic [1:0] PHASE_SUM   = 2'h1;
  localparam logic [1:0] PHASE_OUT_A = 2'h2;
  localparam logic [1:0] PHASE_STF_A = 2'h3;

  typedef enum logic [1:0] {
    MODE_BASE,
    MODE_BASE_STUFF,
    MODE_IF,
    MODE_IF_STUFF
  } idf_mode_type;

endpackage

// ==== core/idf_fifo.sv ====
// Word FIFO between input capture and the interpolation filter.
// Assumes a single clock and a reader that may stall at will.
`timescale 1ns/1ps
module idf_fifo #(
  parameter int WIDTH = 14,
  parameter int DEPTH = 8
) (
  input  wire logic             i_ref_clk,  // Clock
  input  wire logic             i_rst,      // Async reset, high
  input  wire logic             i_valid,    // Write request
  input  wire logic [WIDTH-1:0] i_data,     // Write word
  output logic                  o_ready,    // Room for a word
  output logic                  o_valid,    // Word available
  output logic [WIDTH-1:0]      o_data,     // Head word
  input  wire logic             i_ready     // Reader takes head
);
  localparam int PTR_W = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [WIDTH-1:0] next_mem [DEPTH];
  logic [PTR_W-1:0] wr_ptr, next_wr_ptr, rd_ptr, next_rd_ptr;
  logic [PTR_W:0]   count, next_count;
  logic             push, pop;

  assign o_ready = (count != (PTR_W+1)'(DEPTH));
  assign o_valid = (count != '0);
  assign o_data  = mem[rd_ptr];

  always_comb begin
    push        = i_valid && o_ready;
    pop         = i_ready && o_valid;
    next_mem    = mem;
    next_wr_ptr = wr_ptr;
    next_rd_ptr = rd_ptr;
    if (push) begin
      next_mem[wr_ptr] = i_data;
      next_wr_ptr      = (wr_ptr == PTR_W'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
    end
    if (pop) begin
      next_rd_ptr = (rd_ptr == PTR_W'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
    end
    next_count = count + (PTR_W+1)'(push) - (PTR_W+1)'(pop);
  end

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      mem    <= '{default: '0};
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      mem    <= next_mem;
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count  <= next_count;
    end
  end
endmodule // idf_fifo

// ==== core/idf_tap_pair.sv ====
// One folded tap pair of the symmetric filter: (near + far) * coef.
// Assumes signed two's complement samples; purely combinational.
`timescale 1ns/1ps
module idf_tap_pair
  import idf_pkg::*;
#(
  parameter logic signed [COEF_W-1:0] COEF = 16'sh0000
) (
  input  wire logic signed [DATA_W-1:0] i_near,    // Newer sample
  input  wire logic signed [DATA_W-1:0] i_far,     // Mirrored sample
  output logic signed [PROD_W-1:0]      o_product  // Scaled pair sum
);
  logic signed [DATA_W:0] pair_sum;

  always_comb begin
    pair_sum  = (DATA_W+1)'(i_near) + (DATA_W+1)'(i_far);
    o_product = PROD_W'(pair_sum) * PROD_W'(COEF);
  end
endmodule // idf_tap_pair

// ==== core/idf_datapath.sv ====
// Digital input datapath of an oversampling 14-bit converter.
// Assumes i_ref_clk runs at the update rate, four updates per word.
//
// How it works
// RULE1: Word is captured on the rising edge of the input data clock.
// RULE2: Half-band filter yields two output samples for each input word.
// RULE3: Two static inputs decode to one of four digital modes.
// RULE4: Response select low gives low-pass, high gives high-pass.
// RULE5: Zero-stuff input high stuffs after the filter, whatever response.
// RULE6: With stuffing the converter updates at four times the word rate.
// RULE7: Without stuffing each filter word drives the core at twice rate.
// RULE8: Words up to 160 MSPS in, updates up to 400 MSPS out; here one word per four updates caps input at 100 MSPS.
// RULE9: Straight binary code; all zeros is zero primary current.
// RULE10: All internal timing derives from the one reference clock.
// RULE11: Power-down request idles the datapath to save power.
// RULE12: Filter is 43-tap symmetric half-band, even taps zero but center.
// RULE13: High-pass uses the low-pass set with the center negated.
// RULE14: Stuffing inserts the midscale word after every filter word.
`timescale 1ns/1ps
module idf_datapath
  import idf_pkg::*;
(
  input  wire logic              i_ref_clk,               // Update clock
  input  wire logic              i_rst,                   // Async reset
  input  wire logic              i_data_clk,              // Word clock
  input  wire logic [DATA_W-1:0] i_word,                  // Input word
  input  wire logic              i_filter_response_select,// 1 = high-pass
  input  wire logic              i_zero_stuff_enable,     // 1 = stuff
  input  wire logic              i_power_down_request,    // 1 = sleep
  output logic [DATA_W-1:0]      o_dac_code,              // Core code
  output logic                   o_update,                // High each update while awake
  output logic [1:0]             o_mode,                  // Active mode
  output logic                   o_core_enable,           // Core awake
  output logic                   o_input_ready,           // FIFO room
  output logic                   o_overrun                // Word lost
);

  // ----------------------------------------------------------------
  // Input capture
  // ----------------------------------------------------------------
  logic              data_clk_q, next_data_clk_q;
  logic              cap_valid, next_cap_valid;
  logic [DATA_W-1:0] cap_word, next_cap_word;
  logic              overrun, next_overrun;
  logic              in_ready_q, next_in_ready_q;
  logic              fifo_in_ready, fifo_out_valid, pop;
  logic [DATA_W-1:0] fifo_word;
  logic              pd;
  logic              rise;

  assign pd   = i_power_down_request;
  assign rise = i_data_clk && !data_clk_q;

  always_comb begin
    next_data_clk_q = i_data_clk;
    next_cap_valid  = rise && !pd;                          // RULE1
    next_cap_word   = rise ? i_word : cap_word;             // RULE1
    // A word meeting a full FIFO is lost; flag it until reset
    next_overrun    = overrun || (cap_valid && !fifo_in_ready);
    next_in_ready_q = fifo_in_ready;
  end

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      data_clk_q <= 1'b0;
      cap_valid  <= 1'b0;
      cap_word   <= ZERO_CODE;
      overrun    <= 1'b0;
      in_ready_q <= 1'b0;
    end else begin
      data_clk_q <= next_data_clk_q;
      cap_valid  <= next_cap_valid;
      cap_word   <= next_cap_word;
      overrun    <= next_overrun;
      in_ready_q <= next_in_ready_q;
    end
  end

  // Absorbs jitter between the word clock and the frame cadence
  idf_fifo #(
    .WIDTH (DATA_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .i_ref_clk (i_ref_clk),
    .i_rst     (i_rst),
    .i_valid   (cap_valid),
    .i_data    (cap_word),
    .o_ready   (fifo_in_ready),
    .o_valid   (fifo_out_valid),
    .o_data    (fifo_word),
    .i_ready   (pop)
  );

  // ----------------------------------------------------------------
  // Frame sequencer and half-band filter
  // ----------------------------------------------------------------
  logic [1:0]               phase, next_phase;
  logic signed [DATA_W-1:0] line [LINE_LEN];
  logic signed [DATA_W-1:0] next_line [LINE_LEN];
  logic signed [ACC_W-1:0]  filt_a, next_filt_a, filt_b, next_filt_b;
  logic signed [PROD_W-1:0] prod [NUM_PAIRS];
  logic signed [ACC_W-1:0]  pair_acc;
  logic signed [COEF_W-1:0] center;
  logic                     resp_hp, zero_stuff;
  idf_mode_type             mode, next_mode;

  assign resp_hp    = (mode == MODE_IF) || (mode == MODE_IF_STUFF);
  assign zero_stuff = (mode == MODE_BASE_STUFF) || (mode == MODE_IF_STUFF);
  // Pop only at frame start so one word feeds exactly four updates
  assign pop = (phase == PHASE_LOAD) && !pd && fifo_out_valid; // RULE8

  for (genvar j = 0; j < NUM_PAIRS; j++) begin : g_pair
    idf_tap_pair #(
      .COEF (PAIR_COEF[j])
    ) u_pair (
      .i_near    (line[j]),
      .i_far     (line[LINE_LEN-1-j]),
      .o_product (prod[j])                                  // RULE12
    );
  end

  always_comb begin
    next_phase  = pd ? PHASE_LOAD : phase + 2'h1;           // RULE10
    next_line   = line;
    next_filt_a = filt_a;
    next_filt_b = filt_b;
    pair_acc    = '0;
    center      = resp_hp ? -CENTER_COEF : CENTER_COEF;     // RULE4 RULE13
    unique case ({i_filter_response_select, i_zero_stuff_enable})
      2'b00:   next_mode = MODE_BASE;                       // RULE3
      2'b01:   next_mode = MODE_BASE_STUFF;                 // RULE3
      2'b10:   next_mode = MODE_IF;                         // RULE3
      default: next_mode = MODE_IF_STUFF;                   // RULE3
    endcase
    for (int j = 0; j < NUM_PAIRS; j++) begin
      pair_acc = pair_acc + ACC_W'(prod[j]);
    end
    case (phase)
      PHASE_LOAD: begin
        if (!pd) begin
          for (int k = LINE_LEN-1; k > 0; k--) begin
            next_line[k] = line[k-1];
          end
          // Offset binary to two's complement; empty FIFO feeds zero
          next_line[0] = fifo_out_valid ?
            signed'(fifo_word ^ MIDSCALE_CODE) : '0;         // RULE9
        end
      end
      PHASE_SUM: begin
        // Even phase is the center tap alone, odd phase the folded pairs
        next_filt_a = ACC_W'(line[CENTER_IDX]) * ACC_W'(center); // RULE12
        next_filt_b = pair_acc;                             // RULE2
      end
      default: begin
      end
    endcase
  end

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      phase  <= PHASE_LOAD;
      line   <= '{default: '0};
      filt_a <= '0;
      filt_b <= '0;
      mode   <= MODE_BASE;
    end else begin
      phase  <= next_phase;
      line   <= next_line;
      filt_a <= next_filt_a;
      filt_b <= next_filt_b;
      mode   <= next_mode;
    end
  end

  // ----------------------------------------------------------------
  // Output multiplexer
  // ----------------------------------------------------------------
  logic [DATA_W-1:0] dac_code, next_dac_code;
  logic              update, next_update;
  logic              core_enable, next_core_enable;
  logic [DATA_W-1:0] code_a, code_b;

  // Rescale, saturate, and return to straight binary
  function automatic logic [DATA_W-1:0] to_code(
    input logic signed [ACC_W-1:0] acc);
    logic signed [ACC_W-1:0] scaled;
    logic signed [DATA_W-1:0] clipped;
    scaled = acc >>> COEF_FRAC;
    if (scaled > SAT_HI) begin
      clipped = SAT_HI[DATA_W-1:0];
    end else if (scaled < SAT_LO) begin
      clipped = SAT_LO[DATA_W-1:0];
    end else begin
      clipped = scaled[DATA_W-1:0];
    end
    return clipped ^ MIDSCALE_CODE;                         // RULE9
  endfunction

  assign code_a = to_code(filt_a);
  assign code_b = to_code(filt_b);

  always_comb begin
    next_core_enable = !pd;                                 // RULE11
    next_update      = !pd;                                 // RULE6
    if (pd) begin
      // Park at midscale so both outputs carry equal current
      next_dac_code = MIDSCALE_CODE;                        // RULE11
    end else begin
      case (phase)
        PHASE_OUT_A: next_dac_code = code_a;                // RULE7
        PHASE_STF_A: next_dac_code = zero_stuff ?
                                     MIDSCALE_CODE : code_a; // RULE5 RULE14
        PHASE_LOAD:  next_dac_code = code_b;                // RULE7
        default:     next_dac_code = zero_stuff ?
                                     MIDSCALE_CODE : code_b; // RULE5 RULE14
      endcase
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      dac_code    <= MIDSCALE_CODE;
      update      <= 1'b0;
      core_enable <= 1'b0;
    end else begin
      dac_code    <= next_dac_code;
      update      <= next_update;
      core_enable <= next_core_enable;
    end
  end

  assign o_dac_code    = dac_code;
  assign o_update      = update;
  assign o_mode        = mode;
  assign o_core_enable = core_enable;
  assign o_input_ready = in_ready_q;
  assign o_overrun     = overrun;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);

  sequence s_out_a_held;
    (dac_code == $past(code_a)) ##1 (dac_code == $past(code_a, 2));
  endsequence

  sequence s_stuffed_pair;
    (dac_code == $past(code_a)) ##1 (dac_code == MIDSCALE_CODE);
  endsequence

  a_capture_on_rise: assert property ( // RULE1
    (rise && !pd) |=> (cap_valid && cap_word == $past(i_word)))
    else $error("word not captured on data clock rise");

  // Reset drops on a clock edge; its sampled level keeps that edge out
  a_mode_decode: assert property ( // RULE3
    !i_rst |=> (mode == idf_mode_type'($past(
      {i_filter_response_select, i_zero_stuff_enable}))))
    else $error("mode does not follow the select inputs");

  a_center_sign: assert property ( // RULE13
    (phase == PHASE_SUM && !pd) |=> (filt_a == ($past(resp_hp) ?
      -$past(ACC_W'(line[CENTER_IDX])) * ACC_W'(CENTER_COEF) :
       $past(ACC_W'(line[CENTER_IDX])) * ACC_W'(CENTER_COEF))))
    else $error("center tap sign wrong for response");

  a_plain_hold: assert property ( // RULE7
    (phase == PHASE_OUT_A && !pd && !zero_stuff && !i_power_down_request
      ##1 (!pd && !zero_stuff)) |-> s_out_a_held)
    else $error("filter word not held for two updates");

  a_stuff_insert: assert property ( // RULE14
    (phase == PHASE_OUT_A && !pd && zero_stuff ##1 (!pd && zero_stuff))
      |-> s_stuffed_pair)
    else $error("midscale not inserted after filter word");

  a_phase_cadence: assert property ( // RULE6
    (phase == PHASE_LOAD && !pd && !i_rst) ##1 (!pd [*3])
      |=> (phase == PHASE_LOAD))
    else $error("frame is not four updates long");

  a_pop_frame: assert property ( // RULE8
    pop |-> (phase == PHASE_LOAD) ##1 (phase == PHASE_SUM && !pop))
    else $error("word taken outside frame start");

  a_line_shift: assert property ( // RULE12
    pop |=> (line[LINE_LEN-1] == $past(line[LINE_LEN-2]) &&
             line[0] == signed'($past(fifo_word) ^ MIDSCALE_CODE)))
    else $error("delay line did not shift the new word in");

  a_sleep_park: assert property ( // RULE11
    pd |=> (dac_code == MIDSCALE_CODE && !core_enable && !update))
    else $error("power down did not park the core");

  // A lost word must raise overrun on the next cycle
  a_overrun_set: assert property ( // RULE8
    (cap_valid && !fifo_in_ready) |=> overrun)
    else $error("dropped word did not raise overrun");

endmodule // idf_datapath

// ==== tb/idf_source.sv ====
// Model of the data source that feeds words into the datapath.
// Assumes the bench calls send_word right after a rising ref edge.
`timescale 1ns/1ps
module idf_source
  import idf_pkg::*;
(
  input  wire logic         i_ref_clk,  // Update clock
  output logic              o_data_clk, // Word clock
  output logic [DATA_W-1:0] o_word      // Data word
);
  initial begin
    o_data_clk = 1'b0;
    o_word     = MIDSCALE_CODE;
  end

  // ----------------------------------------------------------------
  // Word transfer
  // ----------------------------------------------------------------
  // Half of 2 keeps one word per four update cycles; 1 overdrives
  task automatic send_word(input logic [DATA_W-1:0] w, input int half);
    o_data_clk <= 1'b1;
    o_word     <= w;
    repeat (half) @(posedge i_ref_clk);
    // Stale data is inverted so a late sample cannot pass as valid
    o_data_clk <= 1'b0;
    o_word     <= ~w;
    repeat (half) @(posedge i_ref_clk);
  endtask
endmodule // idf_source

// ==== tb/idf_datapath_tb_top.sv ====
// Self-checking bench for the interpolating datapath.
// Assumes an empty FIFO feeds midscale, so impulses stand alone.
`timescale 1ns/1ps
module idf_datapath_tb_top;
  import idf_pkg::*;
  logic              i_ref_clk;
  logic              i_rst;
  logic              sel;
  logic              stuff;
  logic              pd;
  logic              data_clk;
  logic [DATA_W-1:0] word;
  logic [DATA_W-1:0] o_dac_code;
  logic [1:0]        o_mode;
  logic              o_update;
  logic              o_core_enable;
  logic              o_input_ready;
  logic              o_overrun;
  int                err_count;
  int                num_checks;
  int                n_out;
  int                sum_out;
  int                first_out;
  int                adj;
  int                saw_full;
  logic              prev_nm;

  idf_datapath idf_datapath_i (
    .i_ref_clk               (i_ref_clk),
    .i_rst                   (i_rst),
    .i_data_clk              (data_clk),
    .i_word                  (word),
    .i_filter_response_select(sel),
    .i_zero_stuff_enable     (stuff),
    .i_power_down_request    (pd),
    .o_dac_code              (o_dac_code),
    .o_update                (o_update),
    .o_mode                  (o_mode),
    .o_core_enable           (o_core_enable),
    .o_input_ready           (o_input_ready),
    .o_overrun               (o_overrun)
  );

  idf_source idf_source_i (
    .i_ref_clk (i_ref_clk),
    .o_data_clk(data_clk),
    .o_word    (word)
  );

  initial begin
    i_ref_clk = 1'b0;
    forever #12.5 i_ref_clk = ~i_ref_clk;
  end

  // ----------------------------------------------------------------
  // Output monitor
  // ----------------------------------------------------------------
  always @(posedge i_ref_clk) begin
    if (o_dac_code !== MIDSCALE_CODE) begin
      if (n_out == 0) first_out = int'(o_dac_code) - 8192;
      n_out   += 1;
      sum_out += int'(o_dac_code) - 8192;
      if (prev_nm) adj += 1;
    end
    prev_nm = (o_dac_code !== MIDSCALE_CODE);
    if (o_input_ready !== 1'b1) saw_full = 1;
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic clr();
    @(negedge i_ref_clk);
    n_out    = 0;
    sum_out  = 0;
    adj      = 0;
    saw_full = 0;
  endtask

  function automatic int prod(input int s, input int c);
    longint p;
    p = longint'(s) * c;
    return int'(p >>> COEF_FRAC);
  endfunction

  // Impulse leaves each pair twice and the center once
  function automatic int exp_sum(input int s, input logic hp);
    int t;
    t = prod(s, hp ? -int'(CENTER_COEF) : int'(CENTER_COEF));
    for (int i = 0; i < NUM_PAIRS; i++) t += 2 * prod(s, int'(PAIR_COEF[i]));
    return t;
  endfunction

  task automatic impulse(input logic hp, input logic st, input int s);
    sel   <= hp;
    stuff <= st;
    repeat (100) @(posedge i_ref_clk);
    check("mode", 32'(o_mode), 32'({hp, st}));
    clr();
    @(posedge i_ref_clk);
    idf_source_i.send_word(DATA_W'(s) ^ MIDSCALE_CODE, 2);
    repeat (140) @(posedge i_ref_clk);
    @(negedge i_ref_clk);
    check("count", n_out, st ? 23 : 46);
    check("sum", sum_out, (st ? 1 : 2) * exp_sum(s, hp));
    check("first", first_out, prod(s, int'(PAIR_COEF[0])));
    if (st) check("adjacent", adj, 0);
    $display("test impulse mode %0d done", {hp, st});
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge i_ref_clk);
    err_count++;
    report_and_stop();
  end

  // ----------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------
  initial begin
    int s;
    i_rst      = 1'b1;
    sel        = 1'b0;
    stuff      = 1'b0;
    pd         = 1'b0;
    err_count  = 0;
    num_checks = 0;
    prev_nm    = 1'b0;
    void'($urandom(32'h9d563f8b));
    repeat (20) @(posedge i_ref_clk);
    i_rst <= 1'b0;
    // Full-scale corners in straight binary
    impulse(1'b0, 1'b0, 8191);
    impulse(1'b1, 1'b1, -8192);
    for (int m = 0; m < 4; m++) begin
      s = 1024 + int'($urandom_range(7167));
      if ($urandom_range(1) == 1) s = -s;
      impulse(m[1], m[0], s);
    end
    // Power-down ignores words and idles the core
    pd <= 1'b1;
    repeat (3) @(posedge i_ref_clk);
    check("core_en", 32'(o_core_enable), 32'h0);
    check("update", 32'(o_update), 32'h0);
    check("pd_code", 32'(o_dac_code), 32'(MIDSCALE_CODE));
    clr();
    @(posedge i_ref_clk);
    idf_source_i.send_word(14'h3fff, 2);
    repeat (8) @(posedge i_ref_clk);
    pd <= 1'b0;
    repeat (140) @(posedge i_ref_clk);
    check("pd_words", n_out, 0);
    check("wake", 32'(o_update), 32'h1);
    $display("test power down done");
    // Source overdrives the rate until the FIFO refuses
    clr();
    @(posedge i_ref_clk);
    for (int i = 0; i < 30; i++) begin
      idf_source_i.send_word(DATA_W'($urandom_range(16383)), 1);
    end
    check("full", saw_full, 1);
    check("overrun", 32'(o_overrun), 32'h1);
    repeat (100) @(posedge i_ref_clk);
    check("drained", 32'(o_input_ready), 32'h1);
    check("sticky", 32'(o_overrun), 32'h1);
    $display("test burst done");
    i_rst <= 1'b1;
    repeat (20) @(posedge i_ref_clk);
    check("rst_code", 32'(o_dac_code), 32'(MIDSCALE_CODE));
    check("rst_flags", 32'({o_update, o_core_enable, o_input_ready,
                            o_overrun, o_mode}), 32'h0);
    i_rst <= 1'b0;
    repeat (2) @(posedge i_ref_clk);
    check("rel_ready", 32'(o_input_ready), 32'h1);
    check("rel_overrun", 32'(o_overrun), 32'h0);
    check("rel_mode", 32'(o_mode), 32'({sel, stuff}));
    check("rel_core", 32'({o_core_enable, o_update}), 32'h3);
    $display("test reset done");
    report_and_stop();
  end
endmodule // idf_datapath_tb_top
